// file: verilog/core_reset_nmi_input_conditioning.sv
`timescale 1ns/100ps
// Function
// - Synchronous inputs are sampled on the rising core clock edge.
// - Every output updates on the rising core clock edge.
// - Asynchronous inputs pass through synchronizers before use.
// - All signals active high except i_rst_n and debug test-logic reset, active low.
// - NMI and debug interrupt are edge detected: one exception per assertion while cold reset is low.
// - Core clock is the single timing reference for all interface signals.
// - A reference clock taken after internal buffering is driven out; the code drives a flop toggling at half the core clock rate.
// - Cold reset produces a reset exception request for full initialization.
// - NMI posts when sampled high one clock after sampled low.
module core_reset_nmi_input_conditioning #(
  parameter int unsigned STRAP_W = 4
) (
  input  wire logic               i_core_clk,                    // Core clock input.
  input  wire logic               i_rst_n,                       // Sync reset, active low.
  input  wire logic               i_cold_reset_in,               // Async cold reset.
  input  wire logic               i_nmi_in,                      // Async NMI.
  input  wire logic               i_debug_interrupt_request_in,  // Async debug interrupt.
  input  wire logic               i_debug_test_logic_reset_n,    // Debug reset, low active.
  input  wire logic [STRAP_W-1:0] i_strap,                       // Static strap inputs.
  output logic                    o_bus_reference_clock_out,     // Buffered reference clock.
  output logic                    o_reset_exception,             // Reset exception pulse.
  output logic                    o_in_reset,                    // Cold reset held level.
  output logic                    o_nmi_exception,               // NMI exception pulse.
  output logic                    o_debug_exception,             // Debug interrupt pulse.
  output logic                    o_debug_logic_reset,           // Debug reset, high active.
  output logic [STRAP_W-1:0]      o_strap                        // Captured straps.
);
  import intake_pkg::*;

  logic cold_s;
  logic nmi_s;
  logic dint_s;

  // Each asynchronous input gets its own multi-flop synchronizer.
  sync_stage #(.STAGES(SYNC_STAGES)) u_sync_cold (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    (i_cold_reset_in),
    .o_sync     (cold_s)
  );
  sync_stage #(.STAGES(SYNC_STAGES)) u_sync_nmi (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    (i_nmi_in),
    .o_sync     (nmi_s)
  );
  sync_stage #(.STAGES(SYNC_STAGES)) u_sync_dint (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    (i_debug_interrupt_request_in),
    .o_sync     (dint_s)
  );

  logic               cold_prev_r, cold_prev_nxt;
  logic               nmi_prev_r, nmi_prev_nxt;
  logic               dint_prev_r, dint_prev_nxt;
  logic               rst_exc_r, rst_exc_nxt;
  logic               in_reset_r, in_reset_nxt;
  logic               nmi_exc_r, nmi_exc_nxt;
  logic               dbg_exc_r, dbg_exc_nxt;
  logic               dbg_rst_r, dbg_rst_nxt;
  logic [STRAP_W-1:0] strap_r, strap_nxt;
  logic               refclk_r, refclk_nxt;

  // Edge detection and strap capture. While cold reset is held the NMI history
  // is forced low, so a level already high at release still posts once.
  always_comb begin
    cold_prev_nxt = cold_s;
    in_reset_nxt  = cold_s;
    rst_exc_nxt   = cold_s & ~cold_prev_r;
    nmi_prev_nxt  = cold_s ? SYNC_RESET : nmi_s;
    nmi_exc_nxt   = ~cold_s & nmi_s & ~nmi_prev_r;
    dint_prev_nxt = dint_s;
    dbg_exc_nxt   = ~cold_s & dint_s & ~dint_prev_r;
    dbg_rst_nxt   = ~i_debug_test_logic_reset_n;
    // Straps are only trusted while cold reset holds them legally changing.
    strap_nxt     = cold_s ? i_strap : strap_r;
    refclk_nxt    = ~refclk_r;
  end

  // All outputs are flops on the single core clock.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cold_prev_r <= 1'h0;
      in_reset_r  <= 1'h0;
      rst_exc_r   <= 1'h0;
      nmi_prev_r  <= SYNC_RESET;
      nmi_exc_r   <= 1'h0;
      dint_prev_r <= SYNC_RESET;
      dbg_exc_r   <= 1'h0;
      dbg_rst_r   <= 1'h0;
      strap_r     <= '0;
      refclk_r    <= 1'h0;
    end else begin
      cold_prev_r <= cold_prev_nxt;
      in_reset_r  <= in_reset_nxt;
      rst_exc_r   <= rst_exc_nxt;
      nmi_prev_r  <= nmi_prev_nxt;
      nmi_exc_r   <= nmi_exc_nxt;
      dint_prev_r <= dint_prev_nxt;
      dbg_exc_r   <= dbg_exc_nxt;
      dbg_rst_r   <= dbg_rst_nxt;
      strap_r     <= strap_nxt;
      refclk_r    <= refclk_nxt;
    end
  end

  // The reference clock is a divided copy taken from a flop, so it carries the
  // same insertion delay as every other output; a trade against a raw clock.
  assign o_bus_reference_clock_out = refclk_r;
  assign o_reset_exception         = rst_exc_r;
  assign o_in_reset                = in_reset_r;
  assign o_nmi_exception           = nmi_exc_r;
  assign o_debug_exception         = dbg_exc_r;
  assign o_debug_logic_reset       = dbg_rst_r;
  assign o_strap                   = strap_r;

  // The edge checks below look at the synchronized levels, not at the raw pins, so
  // they judge the edge logic alone; synchronizer depth is checked on its own.
  // The reset is synchronous, so a flop still shows its reset value one edge
  // after release; checks that compare with a past sample of an output, except the
  // strap check, are gated by the past reset level as well as by the disable condition.

  // Named steps of an NMI assertion as seen after the synchronizer.
  sequence s_nmi_rise;
    !cold_s && nmi_s && !nmi_prev_r;
  endsequence
  sequence s_nmi_held;
    nmi_s && nmi_prev_r;
  endsequence
  sequence s_nmi_pulse;
    o_nmi_exception ##1 !o_nmi_exception;
  endsequence

  // Named steps of a debug interrupt assertion, built the same way.
  sequence s_dbg_rise;
    !cold_s && dint_s && !dint_prev_r;
  endsequence
  sequence s_dbg_held;
    dint_s && dint_prev_r;
  endsequence
  sequence s_dbg_pulse;
    o_debug_exception ##1 !o_debug_exception;
  endsequence

  // Named steps of cold reset: the request rises once and then drops.
  sequence s_cold_rise;
    cold_s && !cold_prev_r;
  endsequence
  sequence s_rst_pulse;
    o_reset_exception ##1 !o_reset_exception;
  endsequence

  // An NMI edge posts one pulse, and the pulse is gone on the following edge.
  a_nmi_posts_once: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_nmi_rise |=> s_nmi_pulse)
    else $error("NMI did not post exactly once on a rising edge.");
  a_nmi_held_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_nmi_held |=> !o_nmi_exception)
    else $error("Held NMI posted another exception.");
  a_dbg_edge_only: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_debug_exception |-> $past(dint_s) && !$past(dint_prev_r) && !$past(cold_s))
    else $error("Debug exception without a rising edge.");
  a_dbg_posts: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_dbg_rise |=> s_dbg_pulse)
    else $error("Debug rising edge lost.");
  a_reset_exc_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(cold_s) |=> s_rst_pulse)
    else $error("Reset exception not a single pulse on cold reset.");
  a_sync_latency: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(cold_s) |-> $past(i_cold_reset_in, 2))
    else $error("Cold reset synchronizer shorter than two stages.");
  a_nmi_hist_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    cold_s |=> !nmi_prev_r)
    else $error("NMI history not low during cold reset.");
  a_debug_rst_pol: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_debug_test_logic_reset_n |=> o_debug_logic_reset)
    else $error("Debug reset polarity wrong.");
  a_strap_frozen: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !cold_s |=> $stable(o_strap))
    else $error("Straps changed outside cold reset.");
  a_refclk_toggle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_bus_reference_clock_out != $past(o_bus_reference_clock_out))
    else $error("Reference clock stalled.");

  // The reset request comes only from a cold reset edge and is one edge wide.
  a_rst_exc_cause: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_reset_exception |-> $past(cold_s) && !$past(cold_prev_r))
    else $error("Reset exception without a cold reset edge.");
  a_rst_exc_posts: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_cold_rise |=> s_rst_pulse)
    else $error("Cold reset edge did not post one reset exception.");

  // The held reset level follows the synchronized cold reset one edge later.
  a_in_reset_level: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_in_reset == $past(cold_s))
    else $error("Reset level does not follow cold reset.");

  // No interrupt pulse may leave while cold reset is held; an NMI still high
  // at release posts once then, which is why the NMI history is kept low.
  a_nmi_masked_cold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    cold_s |=> !o_nmi_exception)
    else $error("NMI posted while cold reset held.");
  a_dbg_masked_cold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    cold_s |=> !o_debug_exception)
    else $error("Debug exception posted while cold reset held.");

  // A held debug request stays quiet, and no pulse is ever two edges wide.
  a_dbg_held_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_dbg_held |=> !o_debug_exception)
    else $error("Held debug request posted another exception.");
  a_nmi_one_wide: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_nmi_exception |=> !o_nmi_exception)
    else $error("NMI pulse wider than one cycle.");
  a_dbg_one_wide: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_debug_exception |=> !o_debug_exception)
    else $error("Debug pulse wider than one cycle.");

  // Synchronizer depth on the interrupt paths: a rise needs two edges of delay.
  a_nmi_sync_depth: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(nmi_s) |-> $past(i_nmi_in, 2))
    else $error("NMI synchronizer shorter than two stages.");
  a_dbg_sync_depth: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(dint_s) |-> $past(i_debug_interrupt_request_in, 2))
    else $error("Debug synchronizer shorter than two stages.");

  // Straps are loaded from the pins on every edge of a held cold reset.
  a_strap_capture: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    cold_s |=> o_strap == $past(i_strap))
    else $error("Straps not captured during cold reset.");

  // A released debug reset pin clears the high-active copy on the next edge.
  a_debug_rst_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_debug_test_logic_reset_n |=> !o_debug_logic_reset)
    else $error("Debug reset copy stuck high.");
endmodule // core_reset_nmi_input_conditioning

// file: verilog/intake_pkg.sv
package intake_pkg;
  // Depth of each asynchronous input synchronizer, in flip-flops.
  localparam int unsigned SYNC_STAGES = 2;
  // Value every synchronizer and edge-detect flop takes under reset.
  localparam logic        SYNC_RESET  = 1'h0;
  // Cycles the reset exception request is held after cold reset asserts.
  localparam int unsigned RESET_REQ_CYCLES = 1;
  localparam logic [3:0]  RESET_REQ_COUNT  = 4'(RESET_REQ_CYCLES);
endpackage

// file: verilog/sync_stage.sv
`timescale 1ns/100ps
module sync_stage #(
  parameter int unsigned STAGES = intake_pkg::SYNC_STAGES
) (
  input  wire logic i_core_clk, // Core clock.
  input  wire logic i_rst_n,    // Synchronous reset, active low.
  input  wire logic i_async,    // Asynchronous input.
  output logic      o_sync      // Synchronized level.
);
  import intake_pkg::*;

  logic [STAGES-1:0] chain_r;
  logic [STAGES-1:0] chain_nxt;

  // Shift the level through the chain; only the last stage is read outside.
  always_comb begin
    chain_nxt = {chain_r[STAGES-2:0], i_async};
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      chain_r <= {STAGES{SYNC_RESET}};
    end else begin
      chain_r <= chain_nxt;
    end
  end

  assign o_sync = chain_r[STAGES-1];
endmodule // sync_stage

// file: verif/sys_partner.sv
`timescale 1ns/100ps
// System logic model: it registers the bench's requests onto the core's lines.
module sys_partner (
  input  wire logic       i_core_clk, // Core clock.
  input  wire logic [3:0] i_req,      // Cold, nmi, debug, test reset low.
  input  wire logic [3:0] i_strap,    // Wanted strap value.
  output logic [3:0]      o_line,     // Driven request lines.
  output logic [3:0]      o_strap     // Driven straps.
);
  initial o_line = 4'h8;
  initial o_strap = 4'h0;
  // Straps move only under cold reset, so a late change of mind is dropped.
  always @(posedge i_core_clk) begin
    o_line <= i_req;
    if (i_req[0]) begin
      o_strap <= i_strap;
    end
  end
endmodule // sys_partner

// file: verif/testbench.sv
`timescale 1ns/100ps
// Queue-checked bench; pulses are matched by kind and by cycle.
module testbench;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] req = 4'h8;
  logic [3:0] want = 4'h0;
  logic [3:0] line, strap, strap_seen, s;
  logic       ref_clk, rst_exc, in_rst, nmi_exc, dbg_exc, dbg_rst, ref_last;
  int         cyc = 0;
  int         errors = 0;
  int         check_count = 0;
  int         exp_q[$];
  int         e;
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  sys_partner sys_partner_inst (.i_core_clk(clk), .i_req(req), .i_strap(want),
    .o_line(line), .o_strap(strap));
  core_reset_nmi_input_conditioning core_reset_nmi_input_conditioning_inst (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_cold_reset_in(line[0]), .i_nmi_in(line[1]),
    .i_debug_interrupt_request_in(line[2]), .i_debug_test_logic_reset_n(line[3]),
    .i_strap(strap), .o_bus_reference_clock_out(ref_clk), .o_reset_exception(rst_exc),
    .o_in_reset(in_rst), .o_nmi_exception(nmi_exc), .o_debug_exception(dbg_exc),
    .o_debug_logic_reset(dbg_rst), .o_strap(strap_seen));
  task automatic check(string name, logic [3:0] seen, logic [3:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Notes the expected pulse, then drives; a zero delay leaves the cycle open.
  // A pulse is due five edges after the note: the request edge, the partner's
  // register, two synchronizer stages and the output flop.
  task automatic drive(logic [3:0] r, int vec, int dly);
    @(negedge clk);
    if (vec != 0) exp_q.push_back(vec * 1048576 + (dly != 0 ? cyc + dly : 0));
    @(posedge clk) req <= r;
  endtask
  // Settled outputs are read at the falling edge, away from the update edge.
  always @(negedge clk) begin
    if (rst_n && {rst_exc, nmi_exc, dbg_exc} !== 3'h0) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 0;
      check("pulse kind", {1'b0, rst_exc, nmi_exc, dbg_exc}, 4'(e / 1048576));
      if (e % 1048576 != 0) check("pulse cycle", 4'(cyc - e % 1048576), 4'h0);
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    void'($urandom(84));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    s = 4'($urandom);
    @(posedge clk) want <= s;
    drive(4'h9, 4, 5);
    repeat (8) @(posedge clk);
    @(negedge clk) check("in reset", {3'h0, in_rst}, 4'h1);
    check("strap capture", strap_seen, s);
    drive(4'h8, 0, 0);
    @(posedge clk) want <= ~s;
    repeat (8) @(posedge clk);
    @(negedge clk) check("in reset", {3'h0, in_rst}, 4'h0);
    check("strap frozen", strap_seen, s);
    // Long random holds with a single low cycle between assertions.
    for (int k = 0; k < 2; k++) repeat (2) begin
      drive(k ? 4'hC : 4'hA, k ? 1 : 2, 5);
      repeat (3 + $urandom % 8) @(posedge clk);
      drive(4'h8, 0, 0);
    end
    repeat (6) @(posedge clk);
    drive(4'h0, 0, 0);
    repeat (4) @(posedge clk);
    @(negedge clk) check("debug reset", {3'h0, dbg_rst}, 4'h1);
    drive(4'h8, 0, 0);
    repeat (4) @(posedge clk);
    @(negedge clk) check("debug reset", {3'h0, dbg_rst}, 4'h0);
    // A held NMI under cold reset posts once, after the reset drops.
    drive(4'hB, 4, 5);
    repeat (8) @(posedge clk);
    drive(4'hA, 2, 5);
    repeat (10) @(posedge clk);
    drive(4'h8, 0, 0);
    repeat (6) @(posedge clk);
    @(negedge clk) ref_last = ref_clk;
    @(negedge clk) check("ref clock", {3'h0, ref_clk}, {3'h0, ~ref_last});
    check("pulses left", 4'(exp_q.size()), 4'h0);
    complete_run();
  end
endmodule // testbench
